// file: design/periph_vector_map.sv
// peripheral address decode with per-vector interrupt flag, enable and request logic
`timescale 1ns/1ps

// How it works
// - a source's condition pulse sets its sticky flag bit
// - software writes decide each source's enable bit
// - a source requests only while its enable and flag are both set; vector 1 requests on its flag alone
// - the request holds until the flag clears, not when the condition goes
// - no request except vector 1 reaches the core without the global enable
// - each vector serves one peripheral; its sources are or-ed together
// - vector 1 is the checksum nonmaskable one; vector 0 is reset entry
// - vector 2 carries the brown-out voltage monitor
// - second port needs 14 pins, third port needs 20 pins
// - vectors 6 and 7 carry the real-time counter and its periodic tick
// - vector 8 is timer A overflow, or low-half underflow when split
// - vector 9 is unused normally, high-half underflow when split
// - vector 10 is timer A compare 0, or low-half compare 0 when split
// - gpio window at 0x001c, core registers at 0x0030
// - watchdog 0x0100, interrupt controller 0x0110, checksum scanner 0x0120
// - event router 0x0180, logic block 0x01c0, pin multiplexer 0x0200
// - port config blocks at 0x0400, 0x0420, 0x0440
// - converters and comparator at 0x0600, 0x0670, 0x0680
// - serial units at 0x0800, 0x0810, 0x0820
// - timers A, B, D at 0x0a00, 0x0a40, 0x0a80
// - nonvolatile controller 0x1000, signature row 0x1100, fuses 0x1280
// - reset, sleep, clock controllers at 0x0040, 0x0050, 0x0060
// - vectors 11 and up lie outside this block
module periph_vector_map #(
    parameter int PIN_COUNT = 20
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // access from the core
    input wire periph_map_pkg::access_t access,
    // interrupt sources, one slot per source of each vector
    input wire logic [periph_map_pkg::NUM_VEC-1:0][periph_map_pkg::SRC_W-1:0] source_event,
    input wire logic [periph_map_pkg::NUM_VEC-1:0][periph_map_pkg::SRC_W-1:0] source_clear,
    input wire logic [periph_map_pkg::NUM_VEC-1:0][periph_map_pkg::SRC_W-1:0] source_enable_wdata,
    input wire logic [periph_map_pkg::NUM_VEC-1:0] source_enable_write,
    input wire logic global_enable,
    input wire logic timer_a_split,
    // results
    output periph_map_pkg::decode_t decode,
    output periph_map_pkg::vector_t vector,
    output logic [periph_map_pkg::NUM_VEC-1:0][periph_map_pkg::SRC_W-1:0] source_flag_bit,
    output logic [periph_map_pkg::NUM_VEC-1:0][periph_map_pkg::SRC_W-1:0] source_enable_bit
);

    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef struct packed {
        periph_map_pkg::decode_t decode;
        periph_map_pkg::vector_t vector;
        logic [periph_map_pkg::NUM_VEC-1:0][periph_map_pkg::SRC_W-1:0] flag;
        logic [periph_map_pkg::NUM_VEC-1:0][periph_map_pkg::SRC_W-1:0] enable;
    } state_t;

    state_t st;
    state_t next_st;

    // which vectors exist on this pin count
    function automatic logic vector_present(input int v);
        if (v == periph_map_pkg::VEC_PORT_SECOND) begin
            return PIN_COUNT >= periph_map_pkg::PINS_SECOND_PORT;
        end
        if (v == periph_map_pkg::VEC_PORT_THIRD) begin
            return PIN_COUNT >= periph_map_pkg::PINS_THIRD_PORT;
        end
        return 1'b1;
    endfunction

    // which windows exist on this pin count
    function automatic logic window_present(input int w);
        if (w == periph_map_pkg::WIN_VPORT_SECOND || w == periph_map_pkg::WIN_PORT_SECOND_CONFIG) begin
            return PIN_COUNT >= periph_map_pkg::PINS_SECOND_PORT;
        end
        if (w == periph_map_pkg::WIN_VPORT_THIRD || w == periph_map_pkg::WIN_PORT_THIRD_CONFIG) begin
            return PIN_COUNT >= periph_map_pkg::PINS_THIRD_PORT;
        end
        return 1'b1;
    endfunction

    // ----------------------------------------
    // decode and vector logic
    // ----------------------------------------
    logic [periph_map_pkg::NUM_VEC-1:0][periph_map_pkg::SRC_W-1:0] active;
    logic [periph_map_pkg::NUM_VEC-1:0] vec_req;

    always_comb begin
        next_st = st;
        // flags: the event wins over a clear in the same cycle
        for (int v = 0; v < periph_map_pkg::NUM_VEC; v++) begin
            next_st.flag[v] = (st.flag[v] & ~source_clear[v]) | source_event[v];
            if (source_enable_write[v]) begin
                next_st.enable[v] = source_enable_wdata[v];
            end
            if (!vector_present(v) || v == 0) begin
                next_st.flag[v] = '0;
                next_st.enable[v] = '0;
            end
        end
        // vector 9 has no source outside split mode
        if (!timer_a_split) begin
            next_st.flag[periph_map_pkg::VEC_TIMER_A_HIGH] = '0;
        end
        // sources per vector: 1 checksum 2 monitor 6/7 counter
        // 8 overflow or low underflow 10 compare 0 or low compare 0
        for (int v = 0; v < periph_map_pkg::NUM_VEC; v++) begin
            active[v] = st.flag[v] & st.enable[v];
            vec_req[v] = |active[v];
        end
        // nonmaskable vector ignores the global enable
        for (int v = 0; v < periph_map_pkg::NUM_VEC; v++) begin
            if (v != periph_map_pkg::VEC_CHECKSUM_NMI && !global_enable) begin
                vec_req[v] = 1'b0;
            end
        end
        vec_req[periph_map_pkg::VEC_CHECKSUM_NMI] = |st.flag[periph_map_pkg::VEC_CHECKSUM_NMI];
        next_st.vector.request = vec_req;
        next_st.vector.pending = 1'b0;
        next_st.vector.word_addr = periph_map_pkg::VEC_RESET;
        // lowest number wins, as a fixed priority
        for (int v = periph_map_pkg::NUM_VEC - 1; v > 0; v--) begin
            if (vec_req[v]) begin
                next_st.vector.pending = 1'b1;
                next_st.vector.word_addr = 8'(v);
            end
        end
        // address decode; windows do not overlap, so at most one hits
        next_st.decode = '0;
        for (int w = 0; w < periph_map_pkg::NUM_WIN; w++) begin
            if (access.valid && window_present(w) && access.addr >= periph_map_pkg::WIN_BASE[w]
                && access.addr < periph_map_pkg::WIN_END[w]) begin
                next_st.decode.select[w] = 1'b1;
                next_st.decode.hit = 1'b1;
                next_st.decode.index = 6'(w);
            end
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign decode = st.decode;
    assign vector = st.vector;
    assign source_flag_bit = st.flag;
    assign source_enable_bit = st.enable;

endmodule

// file: design/periph_map_pkg.sv
// shared constants and carriers for the peripheral decode and vector map
package periph_map_pkg;

    // ----------------------------------------
    // peripheral window bases and sizes
    // ----------------------------------------
    localparam int ADDR_W = 16;
    localparam int NUM_WIN = 34;
    localparam logic [15:0] WIN_BASE [NUM_WIN] = '{
        16'h0000, 16'h0004, 16'h0008, 16'h001c, 16'h0030, 16'h0040, 16'h0050, 16'h0060,
        16'h0080, 16'h00a0, 16'h0100, 16'h0110, 16'h0120, 16'h0140, 16'h0180, 16'h01c0,
        16'h0200, 16'h0400, 16'h0420, 16'h0440, 16'h0600, 16'h0670, 16'h0680, 16'h0800,
        16'h0810, 16'h0820, 16'h0a00, 16'h0a40, 16'h0a80, 16'h0f00, 16'h1000, 16'h1100,
        16'h1280, 16'h1300
    };
    // window end (exclusive) is given per window; it equals the next base only where windows abut
    localparam logic [15:0] WIN_END [NUM_WIN] = '{
        16'h0004, 16'h0008, 16'h000c, 16'h0020, 16'h0040, 16'h0050, 16'h0060, 16'h0080,
        16'h00a0, 16'h00c0, 16'h0110, 16'h0120, 16'h0140, 16'h0180, 16'h01c0, 16'h0200,
        16'h0240, 16'h0420, 16'h0440, 16'h0460, 16'h0670, 16'h0680, 16'h0690, 16'h0810,
        16'h0820, 16'h0830, 16'h0a40, 16'h0a80, 16'h0b00, 16'h0f40, 16'h1100, 16'h1180,
        16'h1300, 16'h1380
    };
    // window indices of the parts that depend on pin count
    localparam int WIN_VPORT_SECOND = 1;
    localparam int WIN_VPORT_THIRD = 2;
    localparam int WIN_PORT_SECOND_CONFIG = 18;
    localparam int WIN_PORT_THIRD_CONFIG = 19;
    localparam int PINS_SECOND_PORT = 14;
    localparam int PINS_THIRD_PORT = 20;

    // ----------------------------------------
    // vectors
    // ----------------------------------------
    localparam int NUM_VEC = 11;
    localparam logic [7:0] VEC_RESET = 8'h00;
    localparam int VEC_CHECKSUM_NMI = 1;
    localparam int VEC_VOLTAGE_MONITOR = 2;
    localparam int VEC_PORT_FIRST = 3;
    localparam int VEC_PORT_SECOND = 4;
    localparam int VEC_PORT_THIRD = 5;
    localparam int VEC_RTC_COUNT = 6;
    localparam int VEC_PERIODIC_TICK = 7;
    localparam int VEC_TIMER_A_OVF = 8;
    localparam int VEC_TIMER_A_HIGH = 9;
    localparam int VEC_TIMER_A_CMP0 = 10;
    localparam int SRC_W = 8;

    // ----------------------------------------
    // carriers
    // ----------------------------------------
    typedef struct packed {
        logic valid;
        logic [ADDR_W-1:0] addr;
    } access_t;

    typedef struct packed {
        logic hit;
        logic [5:0] index;
        logic [NUM_WIN-1:0] select;
    } decode_t;

    typedef struct packed {
        logic pending;
        logic [7:0] word_addr;
        logic [NUM_VEC-1:0] request;
    } vector_t;

endpackage

// file: verification/periph_vector_map_asserts.sv
// concurrent checks on the decode and vector map ports
`timescale 1ns/1ps
module periph_vector_map_asserts #(
    parameter int PIN_COUNT = 20
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // watched ports
    input wire periph_map_pkg::access_t access,
    input wire logic [10:0][7:0] source_event,
    input wire logic [10:0][7:0] source_clear,
    input wire logic [10:0][7:0] source_enable_wdata,
    input wire logic [10:0] source_enable_write,
    input wire logic global_enable,
    input wire logic timer_a_split,
    input wire periph_map_pkg::decode_t decode,
    input wire periph_map_pkg::vector_t vector,
    input wire logic [10:0][7:0] source_flag_bit,
    input wire logic [10:0][7:0] source_enable_bit
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    // flag lands one edge after the event, the request one edge later
    sequence ev_path;
        source_event[3][0] ##1 (source_enable_bit[3][0] && global_enable);
    endsequence
    chk_select_onehot: assert property (decode.hit |-> $onehot(decode.select))
        else $error("select not one-hot");
    chk_miss_none: assert property (!decode.hit |-> decode.select == '0)
        else $error("select without hit");
    chk_flag_sets: assert property (source_event[3][0] |=> source_flag_bit[3][0])
        else $error("flag not set");
    chk_event_request: assert property (ev_path |=> vector.request[3])
        else $error("request missing");
    chk_request_gated: assert property (!(|(source_flag_bit[3] & source_enable_bit[3])) |=> !vector.request[3])
        else $error("request without flag and enable");
    chk_global_gate: assert property (!global_enable [*2] |-> (vector.request & 11'h7fd) == '0)
        else $error("request without global enable");
    chk_lowest_vector: assert property (vector.pending |-> vector.request[vector.word_addr[3:0]]
        && (vector.request & ((11'h1 << vector.word_addr) - 11'h1)) == '0)
        else $error("wrong vector address");
    chk_idle_addr: assert property (!vector.pending |-> vector.word_addr == 8'h00 && vector.request == '0)
        else $error("address without pending");
    chk_absent_port: assert property (PIN_COUNT < 20 |-> source_flag_bit[5] == '0)
        else $error("absent port flagged");
endmodule
bind periph_vector_map periph_vector_map_asserts #(.PIN_COUNT(PIN_COUNT)) i_periph_vector_map_asserts (
    .core_clk(core_clk), .reset(reset), .access(access), .source_event(source_event), .source_clear(source_clear),
    .source_enable_wdata(source_enable_wdata), .source_enable_write(source_enable_write),
    .global_enable(global_enable), .timer_a_split(timer_a_split), .decode(decode), .vector(vector),
    .source_flag_bit(source_flag_bit), .source_enable_bit(source_enable_bit));

// file: verification/core_partner.sv
// processor core model issuing peripheral accesses
`timescale 1ns/1ps
module core_partner (
    // clock
    input wire logic core_clk,
    // access to the decoder
    output periph_map_pkg::access_t access
);
    initial access = '{valid: 1'b0, addr: 16'hffff};
    // called at a falling edge; one access per cycle
    task automatic drive(input logic [15:0] addr);
        access = '{valid: 1'b1, addr: addr};
    endtask
    // an idle bus shows a changed pattern, never the stale address
    task automatic idle;
        access = '{valid: 1'b0, addr: ~access.addr};
    endtask
endmodule

// file: verification/testbench.sv
// self-checking bench for the peripheral decode and vector map
`timescale 1ns/1ps
module testbench;
    logic core_clk = 0;
    logic reset = 1;
    logic [10:0][7:0] ev = '0;
    logic [10:0][7:0] clr = '0;
    logic [10:0][7:0] en_wd = '0;
    logic [10:0] en_wr = '0;
    logic glob = 0;
    logic split = 0;
    int num_errors = 0;
    int check_count = 0;
    periph_map_pkg::access_t access;
    periph_map_pkg::decode_t decode;
    periph_map_pkg::vector_t vector;
    logic [10:0][7:0] flag;
    logic [10:0][7:0] en;
    always #2.5 core_clk = ~core_clk;
    core_partner i_core_partner (.core_clk(core_clk), .access(access));
    // fewer pins: the third port and its vector must vanish
    periph_vector_map #(.PIN_COUNT(14)) i_periph_vector_map (.core_clk(core_clk), .reset(reset), .access(access),
        .source_event(ev), .source_clear(clr), .source_enable_wdata(en_wd), .source_enable_write(en_wr),
        .global_enable(glob), .timer_a_split(split), .decode(decode), .vector(vector),
        .source_flag_bit(flag), .source_enable_bit(en));
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task automatic test_done;
        $display("errors %0d checks %0d", num_errors, check_count);
        if (num_errors == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic t_decode;
        logic [15:0] a [28] = '{16'h001c, 16'h0030, 16'h0040, 16'h0050, 16'h0060, 16'h0100, 16'h0110, 16'h0120,
            16'h0180, 16'h01c0, 16'h0200, 16'h0400, 16'h0420, 16'h0600, 16'h0670, 16'h0680, 16'h0800, 16'h0810,
            16'h0820, 16'h0a00, 16'h0a40, 16'h0a80, 16'h1000, 16'h1100, 16'h1280, 16'h00c0, 16'h0008, 16'h0440};
        int k;
        for (int i = 0; i < 28; i++) begin
            i_core_partner.drive(a[i]);
            @(negedge core_clk);
            k = -1;
            for (int w = 0; w < periph_map_pkg::NUM_WIN; w++)
                if (periph_map_pkg::WIN_BASE[w] == a[i]) k = w;
            // third-port windows do not exist on the 14-pin build
            if (k == periph_map_pkg::WIN_VPORT_THIRD || k == periph_map_pkg::WIN_PORT_THIRD_CONFIG)
                k = -1;
            chk(decode.select, k < 0 ? 64'h0 : 64'h1 << k);
            chk(decode.hit, k >= 0);
            chk(decode.index, k < 0 ? 64'h0 : 64'(k));
        end
        i_core_partner.idle;
    endtask
    task automatic t_irq;
        en_wd[3] = 8'h01;
        en_wr[3] = 1;
        glob = 1;
        ev[3][0] = 1;
        @(negedge core_clk);
        en_wr = '0;
        ev = '0;
        chk(flag[3], 8'h01);
        @(negedge core_clk);
        chk({vector.pending, vector.word_addr}, {1'b1, 8'h03});
        repeat (3) @(negedge core_clk);
        chk(vector.request[3], 1'b1);
        glob = 0;
        ev[1][0] = 1;
        @(negedge core_clk);
        ev = '0;
        @(negedge core_clk);
        chk(vector.request, 11'h002);
        chk(vector.word_addr, 8'h01);
        clr[1][0] = 1;
        clr[3][0] = 1;
        @(negedge core_clk);
        clr = '0;
        repeat (2) @(negedge core_clk);
        chk({vector.pending, flag[3]}, 9'h0);
    endtask
    task automatic t_vectors;
        glob = 1;
        en_wd = {11{8'h80}};
        en_wr = '1;
        for (int s = 0; s < 2; s++) begin
            split = s[0];
            ev = {11{8'h81}};
            @(negedge core_clk);
            ev = '0;
            en_wr = '0;
            // vector 0 and the absent third port keep no enable bits
            for (int v = 0; v < 11; v++)
                chk(en[v], (v == 0 || v == 5) ? 8'h00 : 8'h80);
            for (int v = 0; v < 11; v++)
                chk(flag[v], (v == 0 || v == 5 || (v == 9 && s == 0)) ? 8'h00 : 8'h81);
            @(negedge core_clk);
            chk(vector.request, s ? 11'h7de : 11'h5de);
            clr = '1;
            @(negedge core_clk);
            clr = '0;
        end
        en_wd = '0;
        en_wr = '1;
        ev[3][1] = 1;
        repeat (2) @(negedge core_clk);
        chk({flag[3], vector.request[3]}, {8'h02, 1'b0});
    endtask
    initial begin
        repeat (8) @(negedge core_clk);
        chk({decode, vector}, 64'h0);
        reset = 0;
        @(negedge core_clk);
        t_decode;
        t_irq;
        t_vectors;
        test_done;
    end
    // whole run needs well under a thousand cycles
    initial begin
        #20000;
        num_errors++;
        test_done;
    end
endmodule
